// ### amecr_pkg.sv
/*
 * Constants and carrier types for the headphone and host-override register bank.
 * Assumes an AXI4-Lite slave with 32-bit data and byte addresses.
 */
`default_nettype none
package amecr_pkg;
    // printed offsets are register indexes; byte address is four times the index
    localparam logic [7:0]  HP_CFG_INDEX      = 8'h35;
    localparam logic [7:0]  OVR_INDEX         = 8'h3D;
    localparam logic [11:0] HP_CFG_ADDR       = {2'h0, HP_CFG_INDEX, 2'h0};
    localparam logic [11:0] OVR_ADDR          = {2'h0, OVR_INDEX, 2'h0};
    localparam int          ADDR_W            = 12;
    // headphone configuration fields
    localparam int          HP_TEST_BIT       = 7;
    localparam int          HP_LINL_DIFF_BIT  = 4;
    localparam int          HP_MIC_SUPPLY_PIN_DCOFF_BIT = 3;
    localparam int          HP_DELAY_MUX_BIT  = 2;
    localparam int          HEADPHONE_OUTPUT_MODE_ALIAS_BIT       = 1;
    localparam int          HP_PDN_EN_BIT     = 0;
    localparam logic [7:0]  HP_CFG_MASK       = 8'h9F;
    localparam logic [7:0]  HP_CFG_RESET      = 8'h80;
    // override fields
    localparam int          OVR_RSVD_BIT      = 7;
    localparam int          OVR_LIN_MUTE_BIT  = 5;
    localparam int          OVR_MIX_EN_BIT    = 4;
    localparam int          OVR_MON_BIT       = 3;
    localparam int          OVR_PBO_BIT       = 2;
    localparam int          OVR_MICL_BIT      = 1;
    localparam int          OVR_MICR_BIT      = 0;
    localparam logic [7:0]  OVR_MASK          = 8'hBF;
    localparam logic [7:0]  OVR_RESET         = 8'h00;
    // start-up hold of the output mux selection
    localparam int          MUX_DELAY_US      = 100;
    localparam int          CLK_MHZ           = 50;
    localparam int          MUX_DELAY_CYC     = MUX_DELAY_US * CLK_MHZ;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    typedef enum logic [0:0] {
        AMECR_ST_WAIT = 1'h0,
        AMECR_ST_RUN  = 1'h1
    } amecr_start_t;

    typedef struct packed {
        logic       left_line_amp_on;
        logic       mic_discharge_on;
        logic [1:0] hp_mux_sel;
        logic       hp_differential;
        logic       hp_right_only;
        logic       serial_power_down;
        logic       line_in_mute;
        logic       mixer_force_on;
        logic       monitor_mode;
        logic       playback_mode;
        logic       left_mic_mute;
        logic       right_mic_mute;
    } amecr_ctl_t;

    typedef struct packed {
        logic         awready;
        logic         wready;
        logic         aw_held;
        logic         w_held;
        logic [11:0]  aw_addr;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         arready;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
        logic [7:0]   headphone_misc_config;
        logic [7:0]   host_mode_override;
        amecr_start_t start_st;
        logic [31:0]  start_cnt;
        logic [2:0]   pin_sync;
        logic [2:0]   pin_meta;
        amecr_ctl_t   ctl;
    } amecr_state_t;
endpackage : amecr_pkg
`default_nettype wire

// ### amecr_regs.sv
/*
 * Headphone configuration and host mode-override registers with their control outputs.
 * Assumes an AXI4-Lite master on aclk and asynchronous analog-side status pins.
 */
`timescale 1ns/100ps
`default_nettype none
module amecr_regs
    import amecr_pkg::*;
#(
    parameter int MUX_DELAY = MUX_DELAY_CYC
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // axi4-lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // analog-side inputs
    input  wire logic [1:0]  stored_output_mux_select,
    input  wire logic        mic_supply_off,
    input  wire logic        power_hold_bit,
    // control outputs
    output var  amecr_ctl_t  ctl
);
    amecr_state_t s;
    amecr_state_t next_s;

    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                          input logic [3:0] st, input logic [7:0] m);
        merge8 = st[0] ? (d[7:0] & m) : old;
    endfunction : merge8

    always_comb begin
        logic       wr_go;
        logic       rd_hit;
        logic [7:0] rd_byte;
        logic       mux_ok;
        wr_go   = 1'b0;
        rd_hit  = 1'b0;
        rd_byte = 8'h00;
        mux_ok  = 1'b0;
        next_s  = s;
        next_s.pin_meta = {power_hold_bit, mic_supply_off, 1'b0};
        next_s.pin_sync = s.pin_meta;

        // write: address and data taken in either order, response after both
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
            next_s.awready = 1'b0;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
            next_s.wready = 1'b0;
        end
        wr_go = s.aw_held && s.w_held && !s.bvalid;
        if (wr_go) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            // bit 7 is stored as written; keeping it alone is software's duty
            if (s.aw_addr == HP_CFG_ADDR) begin
                next_s.headphone_misc_config =
                    merge8(s.headphone_misc_config, s.w_data, s.w_strb, HP_CFG_MASK);
            end else if (s.aw_addr == OVR_ADDR) begin
                next_s.host_mode_override =
                    merge8(s.host_mode_override, s.w_data, s.w_strb, OVR_MASK);
            end else begin
                next_s.bresp = RESP_SLVERR;
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid  = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready  = 1'b1;
        end

        // read: one cycle from address to data
        if (s_axi_arvalid && s.arready) begin
            rd_hit = 1'b1;
            next_s.arready = 1'b0;
            next_s.rvalid  = 1'b1;
            next_s.rresp   = RESP_OKAY;
            if (s_axi_araddr == HP_CFG_ADDR) begin
                rd_byte = s.headphone_misc_config;
            end else if (s_axi_araddr == OVR_ADDR) begin
                rd_byte = s.host_mode_override;
            end else begin
                next_s.rresp = RESP_SLVERR;
            end
            next_s.rdata = {24'h000000, rd_byte};
        end
        if (s.rvalid && s_axi_rready && !rd_hit) begin
            next_s.rvalid  = 1'b0;
            next_s.arready = 1'b1;
        end

        // start-up hold of the stored mux selection to let external parts charge
        // the window always runs after reset, so software can still set the delay bit inside it
        case (s.start_st)
            AMECR_ST_WAIT: begin
                mux_ok = !s.headphone_misc_config[HP_DELAY_MUX_BIT];
                if (s.start_cnt >= 32'(MUX_DELAY - 1)) begin
                    next_s.start_st = AMECR_ST_RUN;
                end else begin
                    next_s.start_cnt = s.start_cnt + 32'h00000001;
                end
            end
            AMECR_ST_RUN:  mux_ok = 1'b1;
            default:       next_s.start_st = AMECR_ST_RUN;
        endcase

        next_s.ctl.hp_mux_sel = mux_ok ? stored_output_mux_select : 2'h0;
        next_s.ctl.hp_differential = s.headphone_misc_config[HEADPHONE_OUTPUT_MODE_ALIAS_BIT];
        next_s.ctl.hp_right_only   = s.headphone_misc_config[HEADPHONE_OUTPUT_MODE_ALIAS_BIT];
        next_s.ctl.left_line_amp_on = s.headphone_misc_config[HEADPHONE_OUTPUT_MODE_ALIAS_BIT]
                                      & s.headphone_misc_config[HP_LINL_DIFF_BIT];
        next_s.ctl.mic_discharge_on = s.pin_sync[1]
                                      & ~s.headphone_misc_config[HP_MIC_SUPPLY_PIN_DCOFF_BIT];
        next_s.ctl.serial_power_down = s.pin_sync[2]
                                       & s.headphone_misc_config[HP_PDN_EN_BIT];
        next_s.ctl.line_in_mute   = s.host_mode_override[OVR_LIN_MUTE_BIT];
        next_s.ctl.mixer_force_on = s.host_mode_override[OVR_MIX_EN_BIT];
        next_s.ctl.monitor_mode   = s.host_mode_override[OVR_MON_BIT];
        next_s.ctl.playback_mode  = s.host_mode_override[OVR_PBO_BIT];
        next_s.ctl.left_mic_mute  = s.host_mode_override[OVR_MICL_BIT];
        next_s.ctl.right_mic_mute = s.host_mode_override[OVR_MICR_BIT];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
            s.headphone_misc_config <= HP_CFG_RESET;
            s.host_mode_override    <= OVR_RESET;
            s.start_st <= AMECR_ST_WAIT;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready  = s.wready;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign ctl           = s.ctl;

    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence hp_write_s;
        clk_en && s.aw_held && s.w_held && !s.bvalid && s.aw_addr == HP_CFG_ADDR && s.w_strb[0];
    endsequence

    sequence ovr_write_s;
        clk_en && s.aw_held && s.w_held && !s.bvalid && s.aw_addr == OVR_ADDR && s.w_strb[0];
    endsequence

    sequence aw_take_s;
        clk_en && s_axi_awvalid && s_axi_awready;
    endsequence

    sequence ar_take_s;
        clk_en && s_axi_arvalid && s_axi_arready;
    endsequence

    left_line_gate_a: assert property (ctl.left_line_amp_on |-> ctl.hp_differential)
        else $error("left line amp on outside differential mode");
    discharge_gate_a: assert property (clk_en && s.headphone_misc_config[HP_MIC_SUPPLY_PIN_DCOFF_BIT]
        |=> !ctl.mic_discharge_on)
        else $error("mic discharge with discharge disabled");
    mux_hold_a: assert property (clk_en && s.start_st == AMECR_ST_WAIT
        && s.headphone_misc_config[HP_DELAY_MUX_BIT] |=> ctl.hp_mux_sel == 2'h0)
        else $error("output mux applied during start hold");
    mode_follow_a: assert property (clk_en |=> ctl.hp_differential == $past(s.headphone_misc_config[HEADPHONE_OUTPUT_MODE_ALIAS_BIT]))
        else $error("headphone mode output not following register");
    right_route_a: assert property (clk_en |=> ctl.hp_right_only == $past(s.headphone_misc_config[HEADPHONE_OUTPUT_MODE_ALIAS_BIT]))
        else $error("right path routing mismatch");
    pdn_gate_a: assert property (ctl.serial_power_down |-> $past(s.headphone_misc_config[HP_PDN_EN_BIT]))
        else $error("serial power-down while disabled");
    line_mute_a: assert property (clk_en && s.host_mode_override[OVR_LIN_MUTE_BIT] |=> ctl.line_in_mute)
        else $error("line master mute not applied");
    mic_mutes_a: assert property (clk_en |=> ctl.left_mic_mute == $past(s.host_mode_override[OVR_MICL_BIT])
        && ctl.right_mic_mute == $past(s.host_mode_override[OVR_MICR_BIT]))
        else $error("mic master mute not applied");
    mode_force_a: assert property (clk_en |=> ctl.monitor_mode == $past(s.host_mode_override[OVR_MON_BIT])
        && ctl.playback_mode == $past(s.host_mode_override[OVR_PBO_BIT])
        && ctl.mixer_force_on == $past(s.host_mode_override[OVR_MIX_EN_BIT]))
        else $error("forced mode outputs not following register");
    unused_zero_a: assert property (hp_write_s |=> (s.headphone_misc_config & ~HP_CFG_MASK) == 8'h00
        && (s.host_mode_override & ~OVR_MASK) == 8'h00)
        else $error("undocumented bit stored");
    write_resp_a: assert property (hp_write_s |=> s_axi_bvalid)
        else $error("write response missing");

    // write channel: one transfer at a time, readies stay low until the response is taken
    aw_refuse_a: assert property (aw_take_s |=> !s_axi_awready)
        else $error("write address accepted twice");
    w_refuse_a: assert property (clk_en && s_axi_wvalid && s_axi_wready
        |=> !s_axi_wready)
        else $error("write data accepted twice");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    b_release_a: assert property (clk_en && s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not reopened");
    b_after_both_a: assert property ($rose(s_axi_bvalid)
        |-> $past(s.aw_held) && $past(s.w_held))
        else $error("write response before address and data");
    bresp_code_a: assert property (s_axi_bvalid
        |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
        else $error("write response code illegal");

    // read channel: one cycle from address to data, data stands until taken
    ar_refuse_a: assert property (ar_take_s |=> !s_axi_arready && s_axi_rvalid)
        else $error("read address not answered");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before taken");
    r_release_a: assert property (clk_en && s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not reopened");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    rd_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
        |-> s_axi_rdata == 32'h00000000)
        else $error("unmapped read returns data");
    rd_hp_a: assert property (ar_take_s and s_axi_araddr == HP_CFG_ADDR
        |=> s_axi_rdata[7:0] == $past(s.headphone_misc_config) && s_axi_rresp == RESP_OKAY)
        else $error("headphone register read wrong");
    rd_ovr_a: assert property (ar_take_s and s_axi_araddr == OVR_ADDR
        |=> s_axi_rdata[7:0] == $past(s.host_mode_override) && s_axi_rresp == RESP_OKAY)
        else $error("override register read wrong");

    // register storage: only a strobed write to the matching address changes a register
    hp_load_a: assert property (hp_write_s
        |=> s.headphone_misc_config == ($past(s.w_data[7:0]) & HP_CFG_MASK))
        else $error("headphone register not loaded");
    ovr_load_a: assert property (ovr_write_s
        |=> s.host_mode_override == ($past(s.w_data[7:0]) & OVR_MASK))
        else $error("override register not loaded");
    hp_keep_a: assert property (clk_en && !(s.aw_held && s.w_held && !s.bvalid
        && s.aw_addr == HP_CFG_ADDR && s.w_strb[0]) |=> $stable(s.headphone_misc_config))
        else $error("headphone register changed without write");
    ovr_keep_a: assert property (clk_en && !(s.aw_held && s.w_held && !s.bvalid
        && s.aw_addr == OVR_ADDR && s.w_strb[0]) |=> $stable(s.host_mode_override))
        else $error("override register changed without write");

    // control outputs follow the registers one cycle later
    left_line_follow_a: assert property (clk_en |=> ctl.left_line_amp_on
        == $past(s.headphone_misc_config[HEADPHONE_OUTPUT_MODE_ALIAS_BIT] & s.headphone_misc_config[HP_LINL_DIFF_BIT]))
        else $error("left line amp not following register");
    single_ended_a: assert property (clk_en && !s.headphone_misc_config[HEADPHONE_OUTPUT_MODE_ALIAS_BIT]
        |=> !ctl.left_line_amp_on)
        else $error("left line amp on in single-ended mode");
    discharge_on_a: assert property (clk_en && !s.headphone_misc_config[HP_MIC_SUPPLY_PIN_DCOFF_BIT]
        && s.pin_sync[1] |=> ctl.mic_discharge_on)
        else $error("mic supply not discharged");
    pdn_follow_a: assert property (clk_en |=> ctl.serial_power_down
        == $past(s.pin_sync[2] & s.headphone_misc_config[HP_PDN_EN_BIT]))
        else $error("serial power-down not following hold bit");
    line_unmute_a: assert property (clk_en && !s.host_mode_override[OVR_LIN_MUTE_BIT]
        |=> !ctl.line_in_mute)
        else $error("line mute without master mute");
    mixer_follow_a: assert property (clk_en
        |=> ctl.mixer_force_on == $past(s.host_mode_override[OVR_MIX_EN_BIT]))
        else $error("mixer enable not following register");
    playback_follow_a: assert property (clk_en
        |=> ctl.playback_mode == $past(s.host_mode_override[OVR_PBO_BIT]))
        else $error("playback force not following register");
    right_mute_a: assert property (clk_en
        |=> ctl.right_mic_mute == $past(s.host_mode_override[OVR_MICR_BIT]))
        else $error("right mic mute not following register");

    // mic supply and power hold pins pass two flops before logic reads them
    pin_meta_a: assert property (clk_en
        |=> s.pin_meta[2:1] == $past({power_hold_bit, mic_supply_off}))
        else $error("pin first stage not loaded");
    pin_sync_a: assert property (clk_en |=> s.pin_sync == $past(s.pin_meta))
        else $error("pin second stage not loaded");

    // start-up window and clock enable
    mux_free_a: assert property (clk_en && s.start_st == AMECR_ST_WAIT
        && !s.headphone_misc_config[HP_DELAY_MUX_BIT]
        |=> ctl.hp_mux_sel == $past(stored_output_mux_select))
        else $error("output mux held without delay bit");
    mux_run_a: assert property (clk_en && s.start_st == AMECR_ST_RUN
        |=> ctl.hp_mux_sel == $past(stored_output_mux_select))
        else $error("output mux not applied after start");
    start_once_a: assert property (s.start_st == AMECR_ST_RUN |=> s.start_st == AMECR_ST_RUN)
        else $error("start window entered again");
    start_cnt_a: assert property (s.start_st == AMECR_ST_WAIT |-> s.start_cnt < 32'(MUX_DELAY))
        else $error("start window overran");
    freeze_a: assert property (!clk_en |=> $stable(s))
        else $error("state moved with clock enable low");
endmodule : amecr_regs
`default_nettype wire

// ### amecr_host.sv
/* host controller model: axi4-lite master with wr and rd tasks.
   assumes aclk from the bench; any answer delay is waited out. */
`timescale 1ns/100ps
`default_nettype none
module amecr_host
    import amecr_pkg::*;
(
    // clock
    input  wire logic        aclk,
    // write
    output var  logic [11:0] awaddr,
    output var  logic        awvalid,
    input  wire logic        awready,
    output var  logic [31:0] wdata,
    output var  logic [3:0]  wstrb,
    output var  logic        wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output var  logic        bready,
    // read
    output var  logic [11:0] araddr,
    output var  logic        arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output var  logic        rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        // the factory test bit is never changed: it always goes out at its reset value
        wdata <= (a == HP_CFG_ADDR) ? (d | 32'h80) : d;
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'h7;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
                aw_p = 1'b0;
            end
            if (w_p && wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
                w_p = 1'b0;
            end
        end
        while (!bvalid) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        while (!rvalid) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : amecr_host
`default_nettype wire

// ### amecr_regs_tb_top.sv
/* self-checking bench for amecr_regs: random register and pin traffic.
   assumes amecr_host as bus master and a 50 MHz aclk. */
`timescale 1ns/100ps
`default_nettype none
module amecr_regs_tb_top
    import amecr_pkg::*;
;
    localparam int MUXD = 10;
    logic        aclk, aresetn, clk_en;
    logic [31:0] p, v, d, wdata, rdata;
    logic [11:0] awaddr, araddr;
    logic [7:0]  hp, ov;
    logic [3:0]  s, pin, wstrb;
    logic [1:0]  r, bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    amecr_ctl_t  ctl, saved;
    int          failures, n_compared, seed;
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    amecr_regs #(.MUX_DELAY(MUXD)) i_amecr_regs (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .stored_output_mux_select(pin[3:2]), .mic_supply_off(pin[1]), .power_hold_bit(pin[0]),
        .ctl(ctl));
    amecr_host i_amecr_host (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    function automatic amecr_ctl_t exp_ctl();
        exp_ctl = '{hp[4] & hp[1], ~hp[3] & pin[1], pin[3:2], hp[1], hp[1], hp[0] & pin[0],
                    ov[5], ov[4], ov[3], ov[2], ov[1], ov[0]};
    endfunction : exp_ctl
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    task automatic check(input string name);
        repeat (4) @(posedge aclk);
        i_amecr_host.rd(HP_CFG_ADDR, d, r);
        cmp(d, {24'h0, hp});
        cmp(32'(r), 32'(RESP_OKAY));
        i_amecr_host.rd(OVR_ADDR, d, r);
        cmp(d, {24'h0, ov});
        cmp(32'(ctl), 32'(exp_ctl()));
        $display("test %0s done", name);
    endtask : check
    initial begin
        seed = 22;
        failures = 0;
        n_compared = 0;
        {aresetn, clk_en, pin} = 6'h10;
        hp = HP_CFG_RESET;
        ov = OVR_RESET;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // delay bit is clear after reset, so mux select passes even inside the start-up hold
        repeat (MUXD + 4) @(posedge aclk);
        check("reset");
        i_amecr_host.wr(12'h0D8, 32'hFF, 4'hF, r);
        cmp(32'(r), 32'(RESP_SLVERR));
        i_amecr_host.rd(12'h0D8, d, r);
        cmp(d, 32'h0);
        cmp(32'(r), 32'(RESP_SLVERR));
        check("unmapped");
        for (int i = 0; i < 24; i++) begin
            v = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $random(seed);
            s = (i < 2) ? 4'h1 : 4'($random(seed));
            p = $random(seed);
            pin <= p[3:0];
            i_amecr_host.wr(HP_CFG_ADDR, v, s, r);
            i_amecr_host.wr(OVR_ADDR, v >> 8, s, r);
            if (s[0]) begin
                hp = (v[7:0] | 8'h80) & HP_CFG_MASK;
                ov = v[15:8] & OVR_MASK;
            end
            check("random");
        end
        // clock enable low: pins move, outputs must not
        saved = ctl;
        clk_en <= 1'b0;
        pin <= ~pin;
        repeat (6) @(posedge aclk);
        cmp(32'(ctl), 32'(saved));
        clk_en <= 1'b1;
        check("freeze");
        // mid-run reset, delay bit set inside the start window holds the mux
        pin <= 4'hC;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        hp = HP_CFG_RESET;
        ov = OVR_RESET;
        i_amecr_host.wr(HP_CFG_ADDR, 32'h04, 4'h1, r);
        hp = 8'h84 & HP_CFG_MASK;
        repeat (2) @(posedge aclk);
        cmp(32'(ctl.hp_mux_sel), 32'h0);
        repeat (MUXD) @(posedge aclk);
        check("start hold");
        final_report();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        final_report();
    end
endmodule : amecr_regs_tb_top
`default_nettype wire
